/* scr_core_regs.sv */
`timescale 1ns/1ns
module scr_core_regs
  import scr_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5a3c // Arbitrary identification value
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire scr_spi_in_type spi_in,
  output logic sdo,
  output logic chip_reset,
  output scr_cfg_type cfg
);

  // Elaboration check of the reset duration against the counter width
  if (SRST_CYCLES < 1 || SRST_CYCLES > 31) begin : g_chk
    $error("Whole-chip reset duration does not fit the counter");
  end

  scr_state_type state_q;
  logic sclk_q;
  logic [15:0] sh_q;
  logic [3:0] cnt_q;
  logic rw_q;
  logic [14:0] addr_q;
  logic [7:0] tx_q;
  logic [7:0] ifc_q;
  logic [7:0] dev_q;
  logic [7:0] usr_q;
  logic [4:0] srst_cnt_q;
  logic chip_reset_q;
  logic sdo_q;
  scr_cfg_type cfg_q;

  logic sclk_rise;
  logic sclk_fall;
  logic cmd_done;
  logic byte_done;
  logic wr_stb;
  logic soft_req;
  logic rst_all;
  logic hold;
  logic ascend;
  logic [15:0] sh_next;
  logic [14:0] addr_step;
  logic [14:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] ifc_rd;

  // Frame decode from the sampled serial pins
  assign sh_next = {sh_q[14:0], spi_in.sdi};
  assign sclk_rise = spi_in.sclk & ~sclk_q & ~spi_in.cs_n;
  assign sclk_fall = ~spi_in.sclk & sclk_q & ~spi_in.cs_n;
  assign cmd_done = sclk_rise && (state_q == ST_CMD) && (cnt_q == CMD_LAST);
  assign byte_done = sclk_rise && (state_q == ST_DATA) && (cnt_q == DATA_LAST);
  assign wr_stb = byte_done & ~rw_q;
  assign soft_req = wr_stb && (addr_q == ADDR_IFC) && sh_next[IFC_SRST_BIT];
  assign rst_all = reset | chip_reset_q | soft_req;
  assign hold = usr_q[USR_HOLD_BIT];
  assign ascend = ifc_q[IFC_ASCEND_BIT];

  // Next streaming address
  always_comb begin
    if (hold) begin
      addr_step = addr_q;
    end else if (ascend) begin
      addr_step = addr_q + 15'h0001;
    end else begin
      addr_step = addr_q - 15'h0001;
    end
  end

  // Read data mux; indicator bit forced, reset bit shows the reset in progress
  assign ifc_rd = {chip_reset_q, ifc_q[6:5], 1'b1, ifc_q[3:0]};
  assign rd_addr = cmd_done ? sh_next[14:0] : addr_step;
  always_comb begin
    case (rd_addr)
      ADDR_IFC: rd_data = ifc_rd;
      ADDR_DEV: rd_data = dev_q;
      ADDR_ID_LO: rd_data = MAKER_ID[7:0];
      ADDR_ID_HI: rd_data = MAKER_ID[15:8];
      ADDR_USR: rd_data = usr_q;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial clock history for edge detection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_in.sclk;
    end
  end

  // Frame sequencer: command word, then streamed data bytes
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      state_q <= ST_WAIT;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      rw_q <= 1'b0;
      addr_q <= 15'h0000;
      tx_q <= 8'h00;
    end else if (spi_in.cs_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_CMD;
          cnt_q <= 4'h0;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            sh_q <= sh_next;
            cnt_q <= cnt_q + 4'h1;
            if (cmd_done) begin
              state_q <= ST_DATA;
              cnt_q <= 4'h0;
              rw_q <= sh_next[CMD_RW_BIT];
              addr_q <= sh_next[14:0];
              tx_q <= rd_data;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            sh_q <= sh_next;
            cnt_q <= cnt_q + 4'h1;
            if (byte_done) begin
              cnt_q <= 4'h0;
              addr_q <= addr_step;
              tx_q <= rd_data;
            end
          end else if (sclk_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        ST_WAIT: state_q <= ST_WAIT;
        default: state_q <= ST_WAIT;
      endcase
    end
  end

  // Read data leaves on the dedicated output, changing on falling edges
  always_ff @(posedge clk_sys) begin
    if (rst_all || spi_in.cs_n) begin
      sdo_q <= 1'b0;
    end else if (sclk_fall && (state_q == ST_DATA) && rw_q) begin
      sdo_q <= tx_q[7];
    end
  end

  // Interface config; reset bit is never stored, indicator bit is kept
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      ifc_q <= IFC_RESET;
    end else if (wr_stb && (addr_q == ADDR_IFC)) begin
      ifc_q <= {1'b0, sh_next[6:5], ifc_q[IFC_IND_BIT], sh_next[3:0]};
    end
  end

  // Device operating config
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      dev_q <= DEV_RESET;
    end else if (wr_stb && (addr_q == ADDR_DEV)) begin
      dev_q <= sh_next[7:0];
    end
  end

  // User serial config with the address-hold bit
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      usr_q <= USR_RESET;
    end else if (wr_stb && (addr_q == ADDR_USR)) begin
      usr_q <= sh_next[7:0];
    end
  end

  // Whole-chip reset timer; the request bit clears itself when it expires
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      srst_cnt_q <= 5'h00;
      chip_reset_q <= 1'b0;
    end else begin
      chip_reset_q <= soft_req | (srst_cnt_q > 5'h01);
      if (soft_req) begin
        srst_cnt_q <= SRST_COUNT;
      end else if (srst_cnt_q != 5'h00) begin
        srst_cnt_q <= srst_cnt_q - 5'h01;
      end
    end
  end

  // Operating mode outputs; reserved codes pass through on op_mode, without power-down
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_q <= '{power_down: 1'b0, op_mode: MODE_NORMAL};
    end else begin
      cfg_q.power_down <= (dev_q[1:0] == MODE_POWER_DOWN);
      cfg_q.op_mode <= scr_mode_type'(dev_q[1:0]);
    end
  end

  assign sdo = sdo_q;
  assign chip_reset = chip_reset_q;
  assign cfg = cfg_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_srst_run;
    chip_reset_q [*8] ##1 chip_reset_q [*7];
  endsequence

  a_srst_clear: assert property (soft_req |=> s_srst_run ##1 !chip_reset_q)
    else $error("Whole-chip reset length wrong");
  a_srst_quiet: assert property (chip_reset_q |-> state_q == ST_WAIT)
    else $error("Serial frames accepted during chip reset");
  a_ifc_reset: assert property ($fell(chip_reset_q) |-> ifc_q == IFC_RESET)
    else $error("Interface config not at reset value");
  a_dev_reset: assert property ($fell(chip_reset_q) |-> dev_q == DEV_RESET)
    else $error("Device config not at reset value");
  a_mode_power: assert property ((dev_q[1:0] == MODE_POWER_DOWN) |=> cfg_q.power_down)
    else $error("Power-down mode not reflected");
  a_ind_read: assert property ((cmd_done && sh_next[14:0] == ADDR_IFC)
    |=> tx_q[IFC_IND_BIT])
    else $error("Output indicator read as zero");
  a_id_read: assert property ((cmd_done && sh_next[14:0] == ADDR_ID_LO)
    |=> tx_q == MAKER_ID[7:0])
    else $error("Identification byte wrong");
  // A byte that starts the whole-chip reset clears the address instead of stepping it
  a_addr_up: assert property ((byte_done && !soft_req && !hold && ascend)
    |=> addr_q == $past(addr_q) + 15'h0001)
    else $error("Address did not increment");
  a_addr_down: assert property ((byte_done && !soft_req && !hold && !ascend)
    |=> addr_q == $past(addr_q) - 15'h0001)
    else $error("Address did not decrement");
  a_addr_hold: assert property ((byte_done && !soft_req && hold)
    |=> addr_q == $past(addr_q))
    else $error("Address moved while held");

endmodule // scr_core_regs

/* scr_pkg.sv */
package scr_pkg;
  // Register addresses in the serial map
  localparam logic [14:0] ADDR_IFC = 15'h0000;
  localparam logic [14:0] ADDR_DEV = 15'h0002;
  localparam logic [14:0] ADDR_ID_LO = 15'h000c;
  localparam logic [14:0] ADDR_ID_HI = 15'h000d;
  localparam logic [14:0] ADDR_USR = 15'h0010;
  // Field positions
  localparam int IFC_SRST_BIT = 7;
  localparam int IFC_ASCEND_BIT = 5;
  localparam int IFC_IND_BIT = 4;
  localparam int USR_HOLD_BIT = 0;
  localparam int CMD_RW_BIT = 15;
  // Values after reset
  localparam logic [7:0] IFC_RESET = 8'h30;
  localparam logic [7:0] DEV_RESET = 8'h00;
  localparam logic [7:0] USR_RESET = 8'h00;
  // Frame bit counts, as last index of the bit counter
  localparam logic [3:0] CMD_LAST = 4'hf;
  localparam logic [3:0] DATA_LAST = 4'h7;
  // Whole-chip reset duration, longest time rounds down
  localparam int SRST_TIME_NS = 750;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SRST_CYCLES = SRST_TIME_NS / CLK_PERIOD_NS;
  localparam logic [4:0] SRST_COUNT = 5'(SRST_CYCLES);

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_RSVD1 = 2'h1,
    MODE_RSVD2 = 2'h2,
    MODE_POWER_DOWN = 2'h3
  } scr_mode_type;

  typedef enum logic [3:0] {
    ST_WAIT = 4'h1,
    ST_IDLE = 4'h2,
    ST_CMD = 4'h4,
    ST_DATA = 4'h8
  } scr_state_type;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } scr_spi_in_type;

  typedef struct packed {
    logic power_down;
    scr_mode_type op_mode;
  } scr_cfg_type;
endpackage

/* scr_spi_host.sv */
`timescale 1ns/1ns
module scr_spi_host
  import scr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sdo,
  output scr_spi_in_type spi_in
);
  // System cycles per serial clock level
  localparam int HALF = 3;
  initial spi_in = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
  // One mode 0 bit: sdi set while sclk low, sdo taken at the rise
  task automatic bit_xfer(input logic b, output logic r);
    spi_in.sdi = b;
    repeat (HALF) @(negedge clk_sys);
    spi_in.sclk = 1'b1;
    r = sdo;
    repeat (HALF) @(negedge clk_sys);
    spi_in.sclk = 1'b0;
  endtask
  // Command word, then nbytes bytes, MSB first
  task automatic frame(input logic [15:0] cmd, input int nbytes, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic r;
    rd = 16'h0000;
    spi_in.cs_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    for (int i = 15; i >= 0; i--) bit_xfer(cmd[i], r);
    for (int i = 0; i < 8 * nbytes; i++) begin
      bit_xfer(wd[15 - i], r);
      rd[15 - i] = r;
    end
    repeat (HALF) @(negedge clk_sys);
    spi_in.cs_n = 1'b1;
    spi_in.sdi = ~spi_in.sdi; // Released line shows no stale level
    repeat (HALF) @(negedge clk_sys);
  endtask
endmodule // scr_spi_host

/* spi_core_config_registers_bench.sv */
`timescale 1ns/1ns
module spi_core_config_registers_bench;
  import scr_pkg::*;
  localparam logic [15:0] ID = 16'h5a3c; // Arbitrary identification value
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sdo;
  logic chip_reset;
  scr_cfg_type cfg;
  scr_spi_in_type spi_in;
  logic [15:0] rdv;
  logic [15:0] lfsr = 16'hc836;
  logic [7:0] d;
  int fail_count = 0;
  int num_checks = 0;
  int rst_cycles = 0;
  always #25 clk_sys = ~clk_sys;
  scr_core_regs #(.MAKER_ID(ID)) scr_core_regs_i (.clk_sys(clk_sys), .reset(reset),
    .spi_in(spi_in), .sdo(sdo), .chip_reset(chip_reset), .cfg(cfg));
  scr_spi_host scr_spi_host_i (.clk_sys(clk_sys), .sdo(sdo), .spi_in(spi_in));
  // Length of the whole-chip reset pulse
  always @(negedge clk_sys) if (chip_reset === 1'b1) rst_cycles++;
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Read-back of the interface register: bit 7 not kept, bit 4 fixed high
  function automatic logic [7:0] exp_ifc(input logic [7:0] v);
    return (v & 8'h6f) | 8'h10;
  endfunction
  // Two-byte stream from the low identification byte
  function automatic logic [15:0] exp_id(input logic asc);
    return asc ? {ID[7:0], ID[15:8]} : {ID[7:0], 8'h00};
  endfunction
  task automatic conclude();
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    logic [15:0] r;
    scr_spi_host_i.frame({1'b0, a}, 1, {v, 8'h00}, r);
  endtask
  task automatic rdr(input logic [14:0] a, input int n);
    scr_spi_host_i.frame({1'b1, a}, n, 16'h0000, rdv);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    rdr(ADDR_IFC, 1);
    chk("ifc", {IFC_RESET, 8'h00}, rdv);
    rdr(ADDR_DEV, 1);
    chk("dev", {DEV_RESET, 8'h00}, rdv);
    // Normal and power-down modes, reserved bits at default
    for (int m = 0; m < 4; m += 3) begin
      wr(ADDR_DEV, 8'(m));
      chk("cfg", (m == 3) ? 16'h0007 : 16'h0000, {13'h0, cfg});
      rdr(ADDR_DEV, 1);
      chk("dev_rb", {8'(m), 8'h00}, rdv);
    end
    // Alternating direction, random indicator and read-only writes, then a streamed read
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      d = {2'b00, i[0], lfsr[0], 4'h0};
      wr(ADDR_IFC, d);
      rdr(ADDR_IFC, 1);
      chk("ifc_rb", {exp_ifc(d), 8'h00}, rdv);
      wr(lfsr[1] ? ADDR_ID_HI : ADDR_ID_LO, lfsr[15:8]);
      rdr(ADDR_ID_LO, 2);
      chk("id", exp_id(i[0]), rdv);
    end
    // Address hold keeps one address through the stream
    wr(ADDR_IFC, 8'h20);
    wr(ADDR_USR, 8'h01);
    rdr(ADDR_ID_HI, 2);
    chk("hold", {ID[15:8], ID[15:8]}, rdv);
    // Whole-chip reset, host idle for the reset time
    wr(ADDR_DEV, 8'h03);
    rst_cycles = 0;
    wr(ADDR_IFC, 8'ha0);
    for (int i = 0; i < 40 && (chip_reset === 1'b1 || i < 20); i++) @(negedge clk_sys);
    chk("rst_done", 16'h0000, {15'h0, chip_reset});
    if (chip_reset !== 1'b0) conclude();
    chk("rst_len", 16'(SRST_CYCLES), 16'(rst_cycles));
    chk("cfg_rst", 16'h0000, {13'h0, cfg});
    chk("sdo_idle", 16'h0000, {15'h0, sdo});
    rdr(ADDR_IFC, 1);
    chk("ifc_rst", {IFC_RESET, 8'h00}, rdv);
    rdr(ADDR_ID_LO, 2);
    chk("id_rst", exp_id(1'b1), rdv);
    conclude();
  end
endmodule // spi_core_config_registers_bench
